// ===== inc/sbm_defines.svh
// Constants for the serial booth multiplier and its driving source
// Overview of operation
// - Booth multiply 8-bit signed multiplicand by stream
// - Source sends multiplier serially, LSB first
// - Product leaves serially, LSB first
// - Latches open while load low, hold after
// - Load low clears booth, carry, sum state
// - Load clear acts asynchronously, active low
// - Flip-flops change on rising clock, apart from the load clear
// - Carry-save cells; top cell uses expansion, mode
// - Mode and expansion low mean top device
// - Lower devices: mode high, expansion from above
// - Compare bit pair: add, subtract or shift
// - Source pulses load low in first period
// - First product bit after third period start
// - Source repeats sign bit through period seventeen
// - Full multiplication takes eighteen clock periods
// - Cascade: multiplicand sign fills unused upper inputs
`ifndef SBM_DEFINES_SVH
`define SBM_DEFINES_SVH

`define SBM_X_W        8
`define SBM_P_W        16
`define SBM_EXT_W      3
`define SBM_CNT_W      5
`define SBM_PERIODS    18
`define SBM_LOAD_PER   5'h00
`define SBM_Y_FIRST    5'h01
`define SBM_Y_SIGN     5'h09
`define SBM_OUT_FIRST  5'h02
`define SBM_OUT_LAST   5'h11

`endif

// ===== inc/sbm_pkg.sv
// Types shared by the multiplier device and its source
package sbm_pkg;
`include "sbm_defines.svh"

  // Booth decision for one bit period
  typedef enum logic [2:0] {
    SBM_OP_SHIFT = 3'h1,
    SBM_OP_ADD   = 3'h2,
    SBM_OP_SUB   = 3'h4
  } sbm_op_t;

  // Source sequencer phase
  typedef enum logic [1:0] {
    SBM_IDLE = 2'h1,
    SBM_RUN  = 2'h2
  } sbm_phase_t;

  // Device arithmetic state
  typedef struct packed {
    logic                        prev;
    logic [`SBM_X_W-1:0]         sum;
    logic [`SBM_X_W-1:0]         carry;
    logic signed [`SBM_EXT_W-1:0] ext;
  } sbm_dev_state_t;

  // Source sequencer state
  typedef struct packed {
    sbm_phase_t            phase;
    logic [`SBM_CNT_W-1:0] period;
    logic                  load_n;
    logic                  y;
    logic [`SBM_X_W-1:0]   mcand;
    logic [`SBM_X_W-1:0]   mplier;
    logic [`SBM_P_W-1:0]   prod;
    logic                  done;
  } sbm_src_state_t;

  // Current bit against stored previous bit
  function automatic sbm_op_t sbm_booth(input logic cur, input logic prev);
    unique case ({cur, prev})
      2'h1:    sbm_booth = SBM_OP_ADD;
      2'h2:    sbm_booth = SBM_OP_SUB;
      default: sbm_booth = SBM_OP_SHIFT;
    endcase
  endfunction

endpackage

// ===== inc/sbm_if.sv
// Link between the multiplier device and its driving source
`timescale 1ns/1ps
`include "sbm_defines.svh"
interface sbm_if;
  logic                multiplicand_load_n;
  logic [`SBM_X_W-1:0] multiplicand_in;
  logic                mplier_bit;
  logic                expand;
  logic                mode;
  logic                product_serial_out;

  modport device (
    input  multiplicand_load_n,
    input  multiplicand_in,
    input  mplier_bit,
    input  expand,
    input  mode,
    output product_serial_out
  );

  modport source (
    output multiplicand_load_n,
    output multiplicand_in,
    output mplier_bit,
    output expand,
    output mode,
    input  product_serial_out
  );
endinterface // sbm_if

// ===== core/sbm_cell.sv
// One carry-save adder cell of the arithmetic chain
`timescale 1ns/1ps
module sbm_cell (
  input  wire logic upper_in,
  input  wire logic addend_in,
  input  wire logic carry_in,
  output logic      sum_out,
  output logic      carry_out
);
  // Full add with no carry propagation to neighbours
  always_comb begin
    sum_out   = upper_in ^ addend_in ^ carry_in;
    carry_out = (upper_in & addend_in) | (carry_in & (upper_in ^ addend_in));
  end
endmodule // sbm_cell

// ===== core/sbm_device.sv
// Serial by parallel twos complement Booth multiplier device
`timescale 1ns/1ps
`include "sbm_defines.svh"
module sbm_device
  import sbm_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  sbm_if.device     link
);

  localparam int XW = `SBM_X_W;

  // Multiplicand latches
  logic [XW-1:0]          mcand_q;
  // Registered arithmetic state and its next value
  sbm_dev_state_t         st_q;
  sbm_dev_state_t         st_d;
  // Booth decision for this period
  sbm_op_t                op;
  // Multiplicand widened to nine bits, its negation and the chosen addend
  logic signed [XW:0]     x_wide;
  logic signed [XW:0]     x_neg;
  logic        [XW:0]     addend;
  // Cell outputs and upper inputs
  logic [XW-1:0]          cell_sum;
  logic [XW-1:0]          cell_carry;
  logic [XW-1:0]          upper;
  // Exact sign handling of the top cell
  logic signed [4:0]      top_z;

  // Transparent while load is low, holds from its rising edge
  always_latch begin
    if (!link.multiplicand_load_n) begin
      mcand_q = link.multiplicand_in;
    end
  end

  // Booth recoding of current bit against previous bit
  always_comb begin
    op = sbm_booth(link.mplier_bit, st_q.prev);
  end

  // Top device treats the multiplicand as signed, lower ones as a plain field
  always_comb begin
    if (link.mode) begin
      x_wide = $signed({1'b0, mcand_q});
    end else begin
      x_wide = $signed({mcand_q[XW-1], mcand_q});
    end
    x_neg = -x_wide;
  end

  // Addend picked per Booth decision, so no later correction is needed
  always_comb begin
    unique case (op)
      SBM_OP_ADD: addend = x_wide;
      SBM_OP_SUB: addend = x_neg;
      SBM_OP_SHIFT: addend = '0;
    endcase
  end

  // Each cell below the top takes the sum of the cell above, shifting the register down; the top cell takes expansion
  always_comb begin
    for (int i = 0; i < XW - 1; i++) begin
      upper[i] = st_q.sum[i+1];
    end
    upper[XW-1] = link.expand;
  end

  // Carry-save chain, one cell per multiplicand bit
  for (genvar g = 0; g < XW; g++) begin : g_cell
    sbm_cell u_cell (
      .upper_in  (upper[g]),
      .addend_in (addend[g]),
      .carry_in  (st_q.carry[g]),
      .sum_out   (cell_sum[g]),
      .carry_out (cell_carry[g])
    );
  end

  // Top cell in top-device mode: expansion, addend bit, sign weight, extension
  always_comb begin
    top_z = $signed({4'h0, link.expand})
          + $signed({4'h0, addend[XW-1]})
          - $signed({3'h0, addend[XW], 1'b0})
          + $signed({{2{st_q.ext[2]}}, st_q.ext});
  end

  // Next state of all flip-flops
  always_comb begin
    st_d      = st_q;
    st_d.prev = link.mplier_bit;
    st_d.sum[XW-2:0]   = cell_sum[XW-2:0];
    st_d.carry[XW-2:0] = cell_carry[XW-2:0];
    if (link.mode) begin
      // Lower device: plain carry-save top, upper bits come in on expansion
      st_d.sum[XW-1]   = cell_sum[XW-1];
      st_d.carry[XW-1] = cell_carry[XW-1];
      st_d.ext         = '0;
    end else begin
      // Top device: mode folds the sign extension into the ext register, top carry held at zero
      st_d.sum[XW-1]   = top_z[0];
      st_d.carry[XW-1] = 1'b0;
      st_d.ext         = top_z[3:1];
    end
  end

  // Rising-edge state, cleared at once by a low load
  always_ff @(posedge clk_in or negedge link.multiplicand_load_n) begin
    if (!link.multiplicand_load_n) begin
      st_q <= '0;
    end else if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Product bit leaves from the lowest sum flip-flop
  assign link.product_serial_out = st_q.sum[0];

endmodule // sbm_device

// ===== core/sbm_source.sv
// Driving source: loads multiplicand, streams multiplier, gathers product
`timescale 1ns/1ps
`include "sbm_defines.svh"
module sbm_source
  import sbm_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire logic                start_in,
  input  wire logic [`SBM_X_W-1:0] mcand_in,
  input  wire logic [`SBM_X_W-1:0] mplier_in,
  output logic                     busy_out,
  output logic                     done_out,
  output logic [`SBM_P_W-1:0]      product_out,
  sbm_if.source                    link
);

  sbm_src_state_t        st_q;
  sbm_src_state_t        st_d;
  logic [`SBM_CNT_W-1:0] nxt;
  logic [`SBM_CNT_W-1:0] bit_idx;

  // Sequencer over the eighteen bit periods
  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    nxt       = st_q.period + 5'h01;
    bit_idx   = st_q.period - `SBM_OUT_FIRST;
    unique case (st_q.phase)
      SBM_IDLE: begin
        if (start_in) begin
          st_d.phase  = SBM_RUN;
          st_d.period = `SBM_LOAD_PER;
          st_d.load_n = 1'b0;
          st_d.mcand  = mcand_in;
          st_d.mplier = mplier_in;
          st_d.y      = 1'b0;
        end
      end
      SBM_RUN: begin
        st_d.period = nxt;
        st_d.load_n = 1'b1;
        if (nxt >= `SBM_Y_SIGN) begin
          st_d.y = st_q.mplier[`SBM_X_W-1];
        end else begin
          st_d.y = st_q.mplier[nxt[2:0] - 3'h1];
        end
        if (st_q.period >= `SBM_OUT_FIRST) begin
          st_d.prod[bit_idx[3:0]] = link.product_serial_out;
        end
        if (st_q.period == `SBM_OUT_LAST) begin
          st_d.phase = SBM_IDLE;
          st_d.done  = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q        <= '0;
      st_q.phase  <= SBM_IDLE;
      st_q.load_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Link drive; single top device, so mode and expansion stay low
  assign link.multiplicand_load_n = st_q.load_n;
  // Lone device uses all eight inputs, so no upper sign fill arises
  assign link.multiplicand_in     = st_q.mcand;
  assign link.mplier_bit          = st_q.y;
  assign link.mode                = 1'b0;
  assign link.expand              = 1'b0;
  assign busy_out                 = (st_q.phase == SBM_RUN);
  assign done_out                 = st_q.done;
  assign product_out              = st_q.prod;

endmodule // sbm_source

// ===== test/sbm_monitor.sv
// Assertion checker for the multiplier link
`timescale 1ns/1ps
module sbm_monitor (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       multiplicand_load_n,
  input wire logic [7:0] multiplicand_in,
  input wire logic       mplier_bit,
  input wire logic       expand,
  input wire logic       mode,
  input wire logic       product_serial_out
);
  logic [4:0]  cnt_q;
  logic [7:0]  x_q;
  logic [15:0] y_q;
  logic [15:0] ref_w;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Expected product from latched multiplicand and taken bits
  assign ref_w = {{8{x_q[7]}}, x_q} * y_q;
  // Periods since load release, holding at 1f; 1f after reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= 5'h1f;
    end else if (!multiplicand_load_n) begin
      cnt_q <= 5'h00;
      x_q   <= multiplicand_in;
      y_q   <= 16'h0000;
    end else if (cnt_q != 5'h1f) begin
      cnt_q <= cnt_q + 5'h01;
      if (!cnt_q[4]) y_q[cnt_q[3:0]] <= mplier_bit;
    end
  end
  a_load_clears_out: assert property (!multiplicand_load_n |-> !product_serial_out)
    else $error("output high during load");
  a_rose_out_low: assert property ($rose(multiplicand_load_n) |-> !product_serial_out)
    else $error("output early");
  a_first_bit_and: assert property ($rose(multiplicand_load_n) |=>
    product_serial_out == (x_q[0] & $past(mplier_bit))) else $error("first bit wrong");
  a_product_bit_match: assert property ((cnt_q >= 5'h01 && cnt_q <= 5'h10) |->
    product_serial_out == ref_w[cnt_q - 5'h01]) else $error("product bit wrong");
  a_mode_top_device: assert property (!mode && !expand)
    else $error("not top device");
  a_sign_repeat: assert property ((cnt_q >= 5'h08 && cnt_q <= 5'h0f) |->
    mplier_bit == y_q[7]) else $error("sign not repeated");
  a_load_one_period: assert property ($fell(multiplicand_load_n) |=> multiplicand_load_n)
    else $error("load too long");
  a_run_length: assert property ($rose(multiplicand_load_n) |->
    multiplicand_load_n [*8] ##1 multiplicand_load_n [*8] ##1 multiplicand_load_n)
    else $error("run cut short");
  // Main scenarios
  c_load: cover property ($rose(multiplicand_load_n));
  c_last: cover property (cnt_q == 5'h10);
  c_neg: cover property (cnt_q == 5'h08 && mplier_bit);
endmodule // sbm_monitor

// ===== test/serial_parallel_booth_multiplier_tb.sv
// Self-checking bench for the multiplier device with its source
`timescale 1ns/1ps
module serial_parallel_booth_multiplier_tb;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        start_in = 1'b0;
  logic [7:0]  mcand_in = 8'h00;
  logic [7:0]  mplier_in = 8'h00;
  logic        busy_out;
  logic        done_out;
  logic [15:0] product_out;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  sbm_if link_if ();
  sbm_device sbm_device_inst (.clk_in(clk_in), .rst_in(rst_in), .link(link_if));
  sbm_source sbm_source_inst (.clk_in(clk_in), .rst_in(rst_in), .start_in(start_in),
    .mcand_in(mcand_in), .mplier_in(mplier_in), .busy_out(busy_out),
    .done_out(done_out), .product_out(product_out), .link(link_if));
  sbm_monitor sbm_monitor_inst (.clk_in(clk_in), .rst_in(rst_in),
    .multiplicand_load_n(link_if.multiplicand_load_n),
    .multiplicand_in(link_if.multiplicand_in), .mplier_bit(link_if.mplier_bit),
    .expand(link_if.expand), .mode(link_if.mode),
    .product_serial_out(link_if.product_serial_out));
  // Clock and hang guard
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One run traced on the link; hold keeps start up with new operands
  task automatic run(input logic [7:0] x, input logic [7:0] y, input logic hold,
                     input logic fresh);
    logic [15:0]        yb;
    logic [15:0]        sp;
    logic signed [15:0] ex;
    int                 ld;
    int                 nl;
    int                 k;
    yb = 16'h0000;
    sp = 16'h0000;
    ex = $signed(x) * $signed(y);
    ld = -1;
    nl = 0;
    if (fresh) begin
      @(posedge clk_in);
      start_in  <= 1'b1;
      mcand_in  <= x;
      mplier_in <= y;
    end
    @(posedge clk_in);
    if (hold) begin
      mcand_in  <= ~x;
      mplier_in <= x;
    end else begin
      start_in <= 1'b0;
    end
    for (k = 1; k < 24; k++) begin
      @(negedge clk_in);
      if (link_if.multiplicand_load_n !== 1'b1) begin
        nl++;
        ld = k;
      end
      if (ld > 0 && k - ld >= 1 && k - ld <= 16) yb[k-ld-1] = link_if.mplier_bit;
      if (ld > 0 && k - ld >= 2 && k - ld <= 17) sp[k-ld-2] = link_if.product_serial_out;
      if (done_out === 1'b1) break;
    end
    check(16'(nl), 16'h0001);
    check(yb, {{8{y[7]}}, y});
    check(sp, ex);
    check(product_out, ex);
    check(16'(k - ld), 16'h0012);
  endtask
  // Extreme and mixed operands, every bit-pair decision
  task automatic t_corners();
    logic [15:0] tbl [8];
    tbl = '{16'h8080, 16'h807f, 16'h7f7f, 16'hffff, 16'h00a5, 16'h5aa5, 16'h0180, 16'hc33c};
    foreach (tbl[i]) run(tbl[i][15:8], tbl[i][7:0], 1'b0, 1'b1);
  endtask
  // Second start taken as the first product completes
  task automatic t_back_to_back();
    run(8'h93, 8'h6e, 1'b1, 1'b1);
    run(8'h6c, 8'h93, 1'b0, 1'b0);
  endtask
  // Reset in mid-run, then a clean run
  task automatic t_mid_reset();
    @(posedge clk_in);
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b1;
    @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    check({busy_out, link_if.product_serial_out, link_if.multiplicand_load_n}, 16'h0001);
    run(8'h6b, 8'hd9, 1'b0, 1'b1);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    t_corners();
    t_back_to_back();
    t_mid_reset();
    test_done();
  end
endmodule // serial_parallel_booth_multiplier_tb
